/* tb/pdm_cpu_model.sv */
/*
 Behavioural model of the CPU core and bus controller beside the power-down controller.
 Assumes the bench asks for SLEEP with a one-cycle sleep_req and may stretch bus cycles with stall.
*/
`timescale 1ns/1ns
`default_nettype none
module pdm_cpu_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Bench controls.
  input wire logic sleep_req,
  input wire logic stall,
  // Controller side.
  input wire logic cpu_halt,
  output logic sleep_exec,
  output logic bus_cycle_end
);
  logic [1:0] phase_q;

  // --------------------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------------------
  // Cycles last three clocks; a stall stretches the current one, so a slow bus is possible.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      sleep_exec <= 1'b0;
    end else begin
      if (!stall) begin
        phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      end
      sleep_exec <= sleep_req & ~cpu_halt;
    end
  end
  assign bus_cycle_end = (phase_q == 2'h2) && !stall;
endmodule
`default_nettype wire

/* tb/power_down_mode_controller_bench.sv */
/*
 Self-checking bench for the power-down mode controller.
 Assumes the design package and configuration header on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pdm_cfg.svh"
module power_down_mode_controller_bench;
  import pdm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic stall = 1'b0;
  logic irq_pending = 1'b0;
  logic nmi_pending = 1'b0;
  logic timer_watchdog_irq = 1'b0;
  logic watchdog_mode = 1'b0;
  logic watchdog_reset = 1'b0;
  logic [11:0] ext_irq_wake = 12'h000;
  logic reset_pin_n = 1'b1;
  logic hw_standby_pin = 1'b1;
  logic [15:0] reg_rdata, stop_a_eff, stop_b_eff;
  logic [2:0] ram_stop;
  logic serial_reset, cpu_halt, bus_io_stop, osc_stop, bus_hiz, hw_standby, core_reset;
  logic wake_exception, reset_exception, sleep_exec, bus_cycle_end;
  pdm_sel_type cpu_clock_sel, periph_clock_sel, bus_clock_sel;
  int error_cnt = 0;
  int cmp_count = 0;
  int wake_cnt = 0;
  int rexc_cnt = 0;
  int cycle_cnt = 0;
  int w0, n;

  always #50 clock = ~clock;

  pdm_controller dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .bus_cycle_end(bus_cycle_end), .irq_pending(irq_pending), .nmi_pending(nmi_pending),
    .timer_watchdog_irq(timer_watchdog_irq), .watchdog_mode(watchdog_mode), .watchdog_reset(watchdog_reset),
    .ext_irq_wake(ext_irq_wake), .reset_pin_n(reset_pin_n), .hw_standby_pin(hw_standby_pin),
    .stop_a_eff(stop_a_eff), .stop_b_eff(stop_b_eff), .ram_stop(ram_stop), .serial_reset(serial_reset),
    .cpu_halt(cpu_halt), .bus_io_stop(bus_io_stop), .osc_stop(osc_stop), .bus_hiz(bus_hiz),
    .hw_standby(hw_standby), .core_reset(core_reset), .wake_exception(wake_exception),
    .reset_exception(reset_exception), .cpu_clock_sel(cpu_clock_sel),
    .periph_clock_sel(periph_clock_sel), .bus_clock_sel(bus_clock_sel));

  pdm_cpu_model cpu (.clock(clock), .rst_n(rst_n), .sleep_req(sleep_req), .stall(stall),
    .cpu_halt(cpu_halt), .sleep_exec(sleep_exec), .bus_cycle_end(bus_cycle_end));

  // --------------------------------------------------------------------------
  // Access tasks and checks
  // --------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    // The read word stands through the cycle after the strobe; take it at that cycle's closing edge.
    @(posedge clock);
    d = reg_rdata;
  endtask

  task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask

  // Polls the mode code; the bound keeps a stuck mode from hanging the run.
  task automatic wait_mode(input logic [2:0] m, input int tries);
    logic [15:0] d;
    d = 16'h0000;
    for (int i = 0; i < tries; i++) begin
      rd(`PDM_OFS_STATUS, d);
      if (d[2:0] === m) break;
    end
    chk("mode", {13'h0000, d[2:0]}, {13'h0000, m});
  endtask

  task automatic sleep_cmd();
    @(posedge clock);
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycle_cnt++;
    if (wake_exception === 1'b1) wake_cnt++;
    if (reset_exception === 1'b1) rexc_cnt++;
    if (cycle_cnt == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    rchk("stop_a", `PDM_OFS_STOP_A, 16'h0FFF);
    rchk("stop_b", `PDM_OFS_STOP_B, 16'hFFFF);
    rchk("stop_c", `PDM_OFS_STOP_C, 16'hFF00);
    rchk("clock_sel", `PDM_OFS_CLOCK_SEL, 16'h0000);
    rchk("unmapped", 4'hF, 16'h0000);
    chk("stop_b_eff", stop_b_eff, 16'hFFFF);
    chk("stop_a_eff", stop_a_eff, 16'h0FFF);
    chk("ram_stop", 16'(ram_stop), 16'h0000);
    $display("Test reset values done");
    // A stalled bus cycle is in flight while the stop and clock registers are written, so none of them applies yet.
    stall <= 1'b1;
    wr(`PDM_OFS_STOP_B, 16'h0000);
    wr(`PDM_OFS_STOP_C, 16'h00FD);
    wr(`PDM_OFS_CLOCK_SEL, 16'h0215);
    repeat (3) @(posedge clock);
    chk("stop_b_held", stop_b_eff, 16'hFFFF);
    chk("ram_held", 16'(ram_stop), 16'h0000);
    chk("cpu_sel_held", 16'(cpu_clock_sel), 16'h0000);
    stall <= 1'b0;
    repeat (4) @(posedge clock);
    chk("stop_b_eff", stop_b_eff, 16'h68FF);
    chk("ram_stop", 16'(ram_stop), 16'h0005);
    chk("cpu_sel", 16'(cpu_clock_sel), 16'h0002);
    chk("periph_sel", 16'(periph_clock_sel), 16'h0002);
    chk("bus_sel", 16'(bus_clock_sel), 16'h0005);
    chk("serial_run", 16'(serial_reset), 16'h0000);
    rchk("stop_c", `PDM_OFS_STOP_C, 16'hFF05);
    $display("Test module stop and clocks done");
    sleep_cmd();
    wait_mode(pdm_sleep, 10);
    chk("cpu_halt", 16'(cpu_halt), 16'h0001);
    w0 = wake_cnt;
    irq_pending <= 1'b1;
    wait_mode(pdm_run, 10);
    irq_pending <= 1'b0;
    chk("irq_wake", 16'(wake_cnt - w0), 16'h0001);
    sleep_cmd();
    wait_mode(pdm_sleep, 10);
    watchdog_reset <= 1'b1;
    @(posedge clock);
    watchdog_reset <= 1'b0;
    repeat (6) @(posedge clock);
    wait_mode(pdm_run, 10);
    rchk("stop_b_reload", `PDM_OFS_STOP_B, 16'hFFFF);
    $display("Test sleep done");
    watchdog_mode <= 1'b1;
    wr(`PDM_OFS_STANDBY_CTL, 16'hC500);
    sleep_cmd();
    repeat (4) @(posedge clock);
    wait_mode(pdm_run, 1);
    // Software stops the watchdog before SLEEP.
    watchdog_mode <= 1'b0;
    sleep_cmd();
    wait_mode(pdm_sw_standby, 10);
    chk("osc_stop", 16'(osc_stop), 16'h0001);
    chk("serial_reset", 16'(serial_reset), 16'h0001);
    chk("bus_hiz_hold", 16'(bus_hiz), 16'h0000);
    w0 = wake_cnt;
    n = 0;
    nmi_pending <= 1'b1;
    while (wake_exception !== 1'b1 && n < 60) begin
      @(posedge clock);
      n++;
    end
    nmi_pending <= 1'b0;
    chk("settle", 16'(n >= 32 && n <= 35), 16'h0001);
    wr(`PDM_OFS_STANDBY_CTL, 16'h8100);
    sleep_cmd();
    wait_mode(pdm_sw_standby, 10);
    chk("bus_hiz", 16'(bus_hiz), 16'h0001);
    ext_irq_wake <= 12'h800;
    wait_mode(pdm_run, 20);
    ext_irq_wake <= 12'h000;
    wr(`PDM_OFS_STANDBY_CTL, 16'h0F00);
    $display("Test software standby done");
    wr(`PDM_OFS_STOP_A, 16'hFFFF);
    rchk("stop_a", `PDM_OFS_STOP_A, 16'h9FFF);
    sleep_cmd();
    wait_mode(pdm_all_stop, 10);
    chk("bus_io_stop", 16'(bus_io_stop), 16'h0001);
    chk("stop_a_all", stop_a_eff, 16'hFFFF);
    timer_watchdog_irq <= 1'b1;
    wait_mode(pdm_run, 10);
    timer_watchdog_irq <= 1'b0;
    wr(`PDM_OFS_STOP_B, 16'h0000);
    sleep_cmd();
    wait_mode(pdm_sleep, 10);
    hw_standby_pin <= 1'b0;
    repeat (4) @(posedge clock);
    chk("hw_standby", 16'(hw_standby), 16'h0001);
    wait_mode(pdm_hw_standby, 2);
    // The reset pin is held low across the standby release.
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    hw_standby_pin <= 1'b1;
    repeat (4) @(posedge clock);
    chk("core_reset", 16'(core_reset), 16'h0001);
    w0 = rexc_cnt;
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    chk("core_reset_off", 16'(core_reset), 16'h0000);
    chk("reset_exc", 16'(rexc_cnt - w0), 16'h0001);
    wait_mode(pdm_run, 2);
    $display("Test standby pin and reset pin done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* verilog/pdm_cfg.svh */
/*
 Register offsets, field positions and reset values for the power-down mode controller.
 Assumes inclusion by bare name from the package and the controller.
*/
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define PDM_OFS_STOP_A 4'h0
`define PDM_OFS_STOP_B 4'h1
`define PDM_OFS_STOP_C 4'h2
`define PDM_OFS_CLOCK_SEL 4'h3
`define PDM_OFS_STANDBY_CTL 4'h4
`define PDM_OFS_STATUS 4'h5

// ----------------------------------------------------------------------------
// Reset values and fixed bits
// ----------------------------------------------------------------------------
`define PDM_RST_STOP_A 16'h0FFF
`define PDM_RST_STOP_B 16'hFFFF
`define PDM_RST_STOP_C 16'hFF00
`define PDM_FIX1_STOP_A 16'h0CD6
`define PDM_FIX0_STOP_A 16'h6000
`define PDM_FIX1_STOP_B 16'h68FF
`define PDM_FIX1_STOP_C 16'hFF00
`define PDM_FIX0_STOP_C 16'h00F8
`define PDM_ALL_STOP_A 16'h7FFF
`define PDM_TMR_MASK_A 16'h0F00
`define PDM_ALL_STOP_B 16'hFFFF
`define PDM_RST_CLOCK_SEL 16'h0000
`define PDM_RST_STANDBY_CTL 16'h0F00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PDM_BIT_CLOCK_STOP_EN 15
`define PDM_BIT_STANDBY_SEL 15
`define PDM_BIT_OUTPUT_HOLD 14
`define PDM_STS_LSB 8
`define PDM_ICK_LSB 8
`define PDM_PCK_LSB 4
`define PDM_BCK_LSB 0
`define PDM_SEL_W 3
`define PDM_STS_W 5

`endif

/* verilog/pdm_controller.sv */
/*
 Power-down mode controller: module-stop registers, clock selection, sleep,
 all-module-clock-stop, software and hardware standby sequencing.
 Assumes a CPU that pulses sleep_exec, reports bus-cycle ends and masked
 interrupt requests, and pins that are synchronised by two flip-flops here.
*/
// Added by the designer: the register addresses and the plain strobed port.
// Overview of operation
// RULE1 - Stop B gates pulse gen, serials.
// RULE2 - Stop C bits 2..0 stop RAMs.
// RULE3 - Software never stops RAM during access.
// RULE4 - Stop C reserved bits fixed read values.
// RULE5 - Clock selections applied at bus-cycle end.
// RULE6 - Three selections: system, peripheral, external bus.
// RULE7 - Peripheral, bus clocks limited to system.
// RULE8 - Stop bit halts module at cycle end.
// RULE9 - Clearing stop bit resumes at cycle end.
// RULE10 - Stopped state kept, serials lose state.
// RULE11 - After reset modules stopped, except transfer controller, RAM.
// RULE12 - Stopped module registers not accessible.
// RULE13 - SLEEP with standby bit 0: sleep.
// RULE14 - Enabled unmasked interrupt ends sleep.
// RULE15 - Reset pin low forces reset state.
// RULE16 - Watchdog reset also ends sleep.
// RULE17 - Standby pin low: hardware standby.
// RULE18 - All stopped plus enable: clock stop.
// RULE19 - Clock stop ends on listed wake sources.
// RULE20 - SLEEP with standby bit 1: standby.
// RULE21 - Output-hold bit chooses bus high impedance.
// RULE22 - Watchdog mode refuses software standby.
// RULE23 - Stop A bit 15 enables clock stop.
// RULE24 - Standby wake waits settling count first.
// RULE25 - Standby exits on NMI, IRQ, pins.
`timescale 1ns/1ns
`default_nettype none
`include "pdm_cfg.svh"
module pdm_controller
  import pdm_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // CPU side.
  input wire logic sleep_exec,
  input wire logic bus_cycle_end,
  input wire logic irq_pending,
  input wire logic nmi_pending,
  input wire logic timer_watchdog_irq,
  input wire logic watchdog_mode,
  input wire logic watchdog_reset,
  input wire logic [11:0] ext_irq_wake,
  // Pins from outside the clock domain.
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin,
  // Module clock gating and mode outputs.
  output logic [15:0] stop_a_eff,
  output logic [15:0] stop_b_eff,
  output logic [2:0] ram_stop,
  output logic serial_reset,
  output logic cpu_halt,
  output logic bus_io_stop,
  output logic osc_stop,
  output logic bus_hiz,
  output logic hw_standby,
  output logic core_reset,
  output logic wake_exception,
  output logic reset_exception,
  output pdm_pkg::pdm_sel_type cpu_clock_sel,
  output pdm_pkg::pdm_sel_type periph_clock_sel,
  output pdm_pkg::pdm_sel_type bus_clock_sel
);
  import pdm_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] standby_sync;
    logic [15:0] module_stop_reg_a;
    logic [15:0] module_stop_reg_b;
    logic [15:0] module_stop_reg_c;
    logic [15:0] clock_select_register;
    logic [15:0] standby_control_register;
    logic [15:0] stop_a_eff;
    logic [15:0] stop_b_eff;
    logic [2:0] ram_stop;
    pdm_sel_type ick;
    pdm_sel_type pck;
    pdm_sel_type bck;
    pdm_mode_type mode;
    logic [19:0] settle_cnt;
    logic [15:0] rdata;
    logic wake_exc;
    logic reset_exc;
    logic in_reset;
  } pdm_state_type;

  pdm_state_type s_q;
  pdm_state_type s_d;

  logic pin_rst_low;
  logic pin_standby_low;
  logic all_clock_stop_enable;
  logic all_stopped;
  logic standby_select_bit;
  logic sleep_wake;
  logic stop_wake;
  logic standby_wake;
  logic [19:0] settle_len;

  assign pin_rst_low = ~s_q.rst_sync[1];
  assign pin_standby_low = ~s_q.standby_sync[1];
  // RULE23 clock-stop enable
  assign all_clock_stop_enable = s_q.module_stop_reg_a[`PDM_BIT_CLOCK_STOP_EN];
  // RULE18 all-stopped test
  // The enable bit and the fixed-zero bits share stop A, so they are folded out before
  // the compare; otherwise the test could never hold while the enable is set.
  assign all_stopped = (((s_q.module_stop_reg_a | `PDM_TMR_MASK_A | `PDM_FIX0_STOP_A) & `PDM_ALL_STOP_A)
                        == `PDM_ALL_STOP_A) && (s_q.module_stop_reg_b == `PDM_ALL_STOP_B);
  assign standby_select_bit = s_q.standby_control_register[`PDM_BIT_STANDBY_SEL];
  // RULE14 sleep wake sources
  assign sleep_wake = irq_pending | nmi_pending;
  // RULE19 clock-stop wake sources
  assign stop_wake = nmi_pending | (|ext_irq_wake) | timer_watchdog_irq;
  // RULE25 standby wake sources
  assign standby_wake = nmi_pending | (|ext_irq_wake);
  // Settling count is two to the power of the low four bits of the select field, a cheap stand-in for the table.
  assign settle_len = 20'(1) << s_q.standby_control_register[`PDM_STS_LSB +: 4];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [15:0] ofs_rd;
    ofs_rd = 16'h0000;
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], reset_pin_n};
    s_d.standby_sync = {s_q.standby_sync[0], hw_standby_pin};
    s_d.wake_exc = 1'b0;
    s_d.reset_exc = 1'b0;

    // Register writes; fixed bits are forced so reads always return them.
    if (reg_wr) begin
      case (reg_addr)
        `PDM_OFS_STOP_A: s_d.module_stop_reg_a = (reg_wdata | `PDM_FIX1_STOP_A) & ~`PDM_FIX0_STOP_A;
        // RULE1 reserved ones forced
        `PDM_OFS_STOP_B: s_d.module_stop_reg_b = reg_wdata | `PDM_FIX1_STOP_B;
        // RULE4 reserved bits fixed
        `PDM_OFS_STOP_C: s_d.module_stop_reg_c = (reg_wdata | `PDM_FIX1_STOP_C) & ~`PDM_FIX0_STOP_C;
        `PDM_OFS_CLOCK_SEL: s_d.clock_select_register = reg_wdata;
        `PDM_OFS_STANDBY_CTL: s_d.standby_control_register = reg_wdata;
        default: begin
        end
      endcase
    end
    case (reg_addr)
      `PDM_OFS_STOP_A: ofs_rd = s_q.module_stop_reg_a;
      `PDM_OFS_STOP_B: ofs_rd = s_q.module_stop_reg_b;
      `PDM_OFS_STOP_C: ofs_rd = s_q.module_stop_reg_c;
      `PDM_OFS_CLOCK_SEL: ofs_rd = s_q.clock_select_register;
      `PDM_OFS_STANDBY_CTL: ofs_rd = s_q.standby_control_register;
      `PDM_OFS_STATUS: ofs_rd = {13'h0000, s_q.mode};
      default: ofs_rd = 16'h0000;
    endcase
    s_d.rdata = reg_rd ? ofs_rd : 16'h0000;

    // RULE5 apply at cycle end
    if (bus_cycle_end) begin
      s_d.ick = s_q.clock_select_register[`PDM_ICK_LSB +: `PDM_SEL_W];
      // RULE7 limit to system clock (smaller code is faster)
      s_d.pck = (s_q.clock_select_register[`PDM_PCK_LSB +: `PDM_SEL_W] < s_d.ick)
                ? s_d.ick : s_q.clock_select_register[`PDM_PCK_LSB +: `PDM_SEL_W];
      s_d.bck = (s_q.clock_select_register[`PDM_BCK_LSB +: `PDM_SEL_W] < s_d.ick)
                ? s_d.ick : s_q.clock_select_register[`PDM_BCK_LSB +: `PDM_SEL_W];
      // RULE8 stop at cycle end
      // RULE9 release at cycle end
      s_d.stop_a_eff = s_q.module_stop_reg_a;
      s_d.stop_b_eff = s_q.module_stop_reg_b;
      s_d.ram_stop = s_q.module_stop_reg_c[2:0];
    end

    // Mode sequencer.
    case (s_q.mode)
      pdm_run: begin
        if (sleep_exec) begin
          // RULE22 refuse standby under watchdog
          if (standby_select_bit && !watchdog_mode) begin
            s_d.mode = pdm_sw_standby;
          end else if (!standby_select_bit && all_clock_stop_enable && all_stopped) begin
            s_d.mode = pdm_all_stop;
          end else if (!standby_select_bit) begin
            // RULE13 enter sleep
            s_d.mode = pdm_sleep;
          end
        end
      end
      pdm_sleep: begin
        // RULE14 interrupt wakes
        if (sleep_wake) begin
          s_d.mode = pdm_run;
          s_d.wake_exc = 1'b1;
        end
      end
      pdm_all_stop: begin
        if (stop_wake) begin
          s_d.mode = pdm_run;
          s_d.wake_exc = 1'b1;
        end
      end
      pdm_sw_standby: begin
        // RULE24 restart oscillator then settle
        if (standby_wake) begin
          s_d.mode = pdm_settle;
          s_d.settle_cnt = settle_len;
        end
      end
      pdm_settle: begin
        if (s_q.settle_cnt <= 20'd1) begin
          s_d.mode = pdm_run;
          s_d.wake_exc = 1'b1;
        end else begin
          s_d.settle_cnt = s_q.settle_cnt - 20'd1;
        end
      end
      pdm_hw_standby: begin
        if (!pin_standby_low) begin
          s_d.mode = pdm_run;
        end
      end
      default: s_d.mode = pdm_run;
    endcase

    // RULE16 watchdog reset ends sleep
    if (watchdog_reset && s_q.mode == pdm_sleep) begin
      s_d.mode = pdm_run;
    end

    // RULE15 reset pin forces reset
    // RULE11 modules stopped after reset
    if (pin_rst_low || watchdog_reset || pin_standby_low) begin
      s_d.module_stop_reg_a = `PDM_RST_STOP_A;
      s_d.module_stop_reg_b = `PDM_RST_STOP_B;
      s_d.module_stop_reg_c = `PDM_RST_STOP_C;
      s_d.clock_select_register = `PDM_RST_CLOCK_SEL;
      s_d.standby_control_register = `PDM_RST_STANDBY_CTL;
      s_d.stop_a_eff = `PDM_RST_STOP_A;
      s_d.stop_b_eff = `PDM_RST_STOP_B;
      s_d.ram_stop = 3'b000;
      s_d.mode = pdm_run;
      s_d.in_reset = 1'b1;
    end else if (s_q.in_reset) begin
      s_d.in_reset = 1'b0;
      s_d.reset_exc = 1'b1;
    end
    // RULE17 standby pin to hardware standby
    if (pin_standby_low) begin
      s_d.mode = pdm_hw_standby;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{rst_sync: 2'b00, standby_sync: 2'b11, module_stop_reg_a: `PDM_RST_STOP_A,
               module_stop_reg_b: `PDM_RST_STOP_B, module_stop_reg_c: `PDM_RST_STOP_C,
               clock_select_register: `PDM_RST_CLOCK_SEL, standby_control_register: `PDM_RST_STANDBY_CTL,
               stop_a_eff: `PDM_RST_STOP_A, stop_b_eff: `PDM_RST_STOP_B, ram_stop: 3'b000,
               ick: 3'b000, pck: 3'b000, bck: 3'b000, mode: pdm_run, settle_cnt: 20'h0_0000,
               rdata: 16'h0000, wake_exc: 1'b0, reset_exc: 1'b0, in_reset: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  // RULE12 stopped modules' registers blocked via these gates downstream
  assign stop_a_eff = (s_q.mode == pdm_all_stop) ? (s_q.stop_a_eff | ~`PDM_TMR_MASK_A) : s_q.stop_a_eff;
  assign stop_b_eff = s_q.stop_b_eff;
  // RULE2 RAM block stop
  assign ram_stop = s_q.ram_stop;
  // RULE10 serial units lose state when stopped
  // Bit 11 is a fixed one and must not count as a stopped serial unit.
  assign serial_reset = (|{s_q.stop_b_eff[12], s_q.stop_b_eff[10:8]}) | (s_q.mode == pdm_sw_standby);
  assign cpu_halt = (s_q.mode != pdm_run);
  // RULE18 bus and ports stop
  assign bus_io_stop = (s_q.mode == pdm_all_stop) || (s_q.mode == pdm_sw_standby) || (s_q.mode == pdm_settle);
  // RULE20 oscillator stops in software standby
  assign osc_stop = (s_q.mode == pdm_sw_standby);
  // RULE21 output hold choice
  assign bus_hiz = (s_q.mode == pdm_sw_standby) && !s_q.standby_control_register[`PDM_BIT_OUTPUT_HOLD];
  assign hw_standby = (s_q.mode == pdm_hw_standby);
  assign core_reset = s_q.in_reset;
  assign wake_exception = s_q.wake_exc;
  assign reset_exception = s_q.reset_exc;
  // RULE6 three selections
  assign cpu_clock_sel = s_q.ick;
  assign periph_clock_sel = s_q.pck;
  assign bus_clock_sel = s_q.bck;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_stop_b_ones: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    $past(reg_rd) && ($past(reg_addr) == `PDM_OFS_STOP_B)
    |-> ((reg_rdata & `PDM_FIX1_STOP_B) == `PDM_FIX1_STOP_B)) else $error("stop B reserved bits not one");
  a_ram_stop_hold: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    !$past(bus_cycle_end) && !$past(pin_rst_low) && !$past(watchdog_reset) && !$past(pin_standby_low)
    |-> $stable(ram_stop)) else $error("RAM stop moved mid cycle");
  a_stop_c_fixed: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    $past(reg_rd) && $past(reg_addr) == `PDM_OFS_STOP_C
    |-> reg_rdata[15:3] == 13'h1FE0) else $error("stop C fixed bits");
  a_clock_sel_edge: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    !$past(bus_cycle_end) && !$past(pin_rst_low) && !$past(watchdog_reset) && !$past(pin_standby_low)
    |-> $stable(cpu_clock_sel)) else $error("clock selection changed mid cycle");
  a_periph_limit: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    periph_clock_sel >= cpu_clock_sel && bus_clock_sel >= cpu_clock_sel) else $error("clock above system clock");
  a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n) // RULE13
    s_q.mode == pdm_run && sleep_exec && !standby_select_bit && !(all_clock_stop_enable && all_stopped)
    && !pin_rst_low && !pin_standby_low && !watchdog_reset |=> cpu_halt && !osc_stop) else $error("sleep not entered");
  a_sleep_wake: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
    s_q.mode == pdm_sleep && sleep_wake && !pin_rst_low && !pin_standby_low && !watchdog_reset
    |=> !cpu_halt && wake_exception) else $error("sleep wake missed");
  a_watchdog_wake: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
    s_q.mode == pdm_sleep && watchdog_reset && !pin_standby_low |=> !cpu_halt && core_reset)
    else $error("watchdog reset left sleep untouched");
  a_hw_standby: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
    pin_standby_low |=> hw_standby) else $error("standby pin ignored");
  a_clock_stop_entry: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
    s_q.mode == pdm_run && sleep_exec && !standby_select_bit && all_clock_stop_enable && all_stopped
    && !pin_rst_low && !pin_standby_low && !watchdog_reset |=> bus_io_stop) else $error("clock stop not entered");
  a_standby_entry: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
    s_q.mode == pdm_run && sleep_exec && standby_select_bit && !watchdog_mode
    && !pin_rst_low && !pin_standby_low && !watchdog_reset |=> osc_stop && cpu_halt) else $error("standby not entered");
  a_watchdog_refuse: assert property (@(posedge clock) disable iff (!rst_n) // RULE22
    s_q.mode == pdm_run && sleep_exec && watchdog_mode |=> !osc_stop) else $error("standby under watchdog");
endmodule
`default_nettype wire

/* verilog/pdm_pkg.sv */
/*
 Types for the power-down mode controller.
 Assumes pdm_cfg.svh on the include path.
*/
package pdm_pkg;
  `include "pdm_cfg.svh"

  typedef enum logic [2:0] {
    pdm_run, pdm_sleep, pdm_all_stop, pdm_sw_standby, pdm_settle, pdm_hw_standby
  } pdm_mode_type;

  typedef logic [2:0] pdm_sel_type;
endpackage
